// File: scanner_read_command_unit.sv
// read command interpreter of a sheet-fed scanner target
// fed by the target's command phase logic with the command block one byte
// at a time; returns data-in bytes and ending status on the same clock
//
// Functional notes
// - Ten-byte read command, operation code 28h, decoded by the target.
// - Type 00h image, 80h pixel count, 81h paper; 02h/03h download only.
// - Type code decoded by the same decoder as the download command.
// - Image reads take the window identifier from command byte 5.
// - Bytes 6..8 hold a 24-bit byte count, most significant first.
// - Zero count moves no data and ends with good status.
// - Short transfer ends with check status, ILI, valid and the residue.
// - Reservation conflict ends with conflict status and no data.
// - Binary image packs eight pixels per byte, leftmost in bit 7.
// - Pixel counts only after window set and before any image read.
// - Pixel count is resolution times extent divided by 1200.
// - Pixel reply: 16 bytes, X in 0..3, Y in 4..7, rest zero.
// - Paper reply: 8 bytes, byte 2 separator 80h/00h, byte 3 size.
// - Size byte bit 7 zero, bit 6 loaded, valid after positioning.
// - Size byte bit 5 set when no size recognised.
// - Size byte bit 4 orientation, one for landscape.
// - Low nibble gives the size code; others reserved.
`timescale 1ns/10ps
`include "scanner_read_consts.svh"
module scanner_read_command_unit #(
   parameter bit LARGE_MODEL = 1'b1,
   parameter int RES_W = 16,
   parameter int EXT_W = 24
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // command block bytes
   input wire logic cdb_valid_i,
   input wire logic [7:0] cdb_byte_i,
   output logic cdb_ready_o,
   // conditions from the rest of the target
   input wire logic resv_conflict_i,
   input wire logic win_set_i,
   input wire logic [RES_W-1:0] x_res_i,
   input wire logic [RES_W-1:0] y_res_i,
   input wire logic [EXT_W-1:0] width_i,
   input wire logic [EXT_W-1:0] length_i,
   // paper detection results
   input wire logic sep_sheet_i,
   input wire logic pos_done_i,
   input wire logic paper_loaded_i,
   input wire logic size_known_i,
   input wire logic landscape_i,
   input wire logic [3:0] size_code_i,
   // binary image pixels
   input wire logic pix_valid_i,
   input wire logic pix_i,
   input wire logic pix_last_i,
   input wire logic img_end_i,
   output logic pix_ready_o,
   output logic img_xfer_o,
   output logic [7:0] win_id_o,
   // data-in stream
   output logic din_valid_o,
   output logic [7:0] din_data_o,
   input wire logic din_ready_i,
   // ending status and sense
   output logic cmd_done_o,
   output logic busy_o,
   output logic [7:0] status_o,
   output logic [3:0] sense_key_o,
   output logic [7:0] asc_o,
   output logic ili_o,
   output logic info_valid_o,
   output logic [31:0] info_o
);
   import scanner_read_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // declarations
   rd_state_t q;
   rd_state_t d;
   logic push;
   logic [7:0] push_data;
   logic buf_ready;
   logic buf_empty;
   logic pk_valid;
   logic [7:0] pk_byte;
   logic pk_ready;
   logic [39:0] prod_x;
   logic [39:0] prod_y;
   logic [7:0] paper_byte;
   logic size_ok;
   logic [7:0] resp_byte;
   logic [23:0] resp_len;

   ////////////////////////////////////////////////////////////////////////
   // image packer and output buffer
   rd_pix_pack u_pack (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .pix_valid_i(pix_valid_i & img_xfer_o),
      .pix_i(pix_i),
      .last_i(pix_last_i),
      .pix_ready_o(pix_ready_o),
      .byte_valid_o(pk_valid),
      .byte_o(pk_byte),
      .byte_ready_i(pk_ready)
   );

   rd_skid_buf2 #(.WIDTH(8)) u_buf (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(push),
      .in_data_i(push_data),
      .in_ready_o(buf_ready),
      .out_valid_o(din_valid_o),
      .out_data_o(din_data_o),
      .out_ready_i(din_ready_i),
      .empty_o(buf_empty)
   );

   ////////////////////////////////////////////////////////////////////////
   // pixel counts from window geometry
   assign prod_x = 40'(x_res_i) * 40'(width_i);
   assign prod_y = 40'(y_res_i) * 40'(length_i);

   // paper size byte; sizes the smaller model cannot see read as unknown
   always_comb begin
      size_ok = 1'b0;
      unique case (size_code_i)
         `SIZE_A4, `SIZE_A5, `SIZE_B5: size_ok = 1'b1;
         `SIZE_A3, `SIZE_B4: size_ok = LARGE_MODEL;
         default: size_ok = 1'b0;
      endcase
      paper_byte[7] = 1'b0;
      paper_byte[6] = paper_loaded_i & pos_done_i;
      paper_byte[5] = ~(size_known_i & size_ok);
      paper_byte[4] = landscape_i;
      paper_byte[3:0] = (size_known_i & size_ok) ? size_code_i : `SIZE_NONE;
   end

   ////////////////////////////////////////////////////////////////////////
   // reply byte for the current count, fixed-format replies only
   always_comb begin
      resp_byte = 8'h00;
      resp_len = `RESP_PAPER_LEN;
      if (q.cls == CLS_PIXEL) begin
         resp_len = `RESP_PIX_LEN;
         if (q.cnt < `PIX_X_END)
            resp_byte = q.px_x[8'(24'd31 - (q.cnt[1:0] * 24'd8)) -: 8];
         else if (q.cnt < `PIX_Y_END)
            resp_byte = q.px_y[8'(24'd31 - (q.cnt[1:0] * 24'd8)) -: 8];
      end else begin
         if (q.cnt == `PAPER_SEP_BYTE)
            resp_byte = q.paper[7] ? `SEP_SHEET_SEEN : `SEP_SHEET_NONE;
         else if (q.cnt == `PAPER_SIZE_BYTE)
            resp_byte = {1'b0, q.paper[6:0]};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // command controller
   always_comb begin
      d = q;
      d.win_q = win_set_i; // previous window level for edge detection
      push = 1'b0;
      push_data = 8'h00;
      pk_ready = 1'b0;
      unique case (q.st)
         ST_IDLE: begin
            if (cdb_valid_i) begin
               // collect the command block
               unique case (q.idx)
                  `CDB_OP: d.op = cdb_byte_i;
                  `CDB_DTC: d.dtc = cdb_byte_i;
                  `CDB_WID: d.wid = cdb_byte_i;
                  `CDB_LEN_HI: d.len[23:16] = cdb_byte_i;
                  `CDB_LEN_MID: d.len[15:8] = cdb_byte_i;
                  `CDB_LEN_LO: d.len[7:0] = cdb_byte_i;
                  default: ;
               endcase
               if (q.idx == `CDB_LEN - 4'd1) begin
                  d.idx = 4'd0;
                  d.st = ST_DEC;
               end else begin
                  d.idx = q.idx + 4'd1;
               end
            end
         end
         ST_DEC: begin
            d.cls = dtc_class(q.dtc);
            d.cnt = 24'd0;
            d.stat = `STAT_GOOD;
            d.skey = `SK_NONE;
            d.asc = `ASC_NONE;
            d.ili = 1'b0;
            d.info_vld = 1'b0;
            d.resid = 24'd0;
            d.px_x = 32'(prod_x / `PIX_DIV);
            d.px_y = 32'(prod_y / `PIX_DIV);
            d.paper = {sep_sheet_i, paper_byte[6:0]};
            d.st = ST_DONE;
            if (q.op != `OP_READ10) begin
               d.stat = `STAT_CHECK;
               d.skey = `SK_ILLEGAL;
               d.asc = `ASC_BAD_OPCODE;
            end else if (resv_conflict_i) begin
               d.stat = `STAT_RESV;
            end else if (dtc_class(q.dtc) == CLS_BAD || dtc_class(q.dtc) == CLS_DOWNLOAD) begin
               d.stat = `STAT_CHECK;
               d.skey = `SK_ILLEGAL;
               d.asc = `ASC_BAD_FIELD;
            end else if (dtc_class(q.dtc) == CLS_PIXEL && (!win_set_i || q.img_rd)) begin
               d.stat = `STAT_CHECK;
               d.skey = `SK_ILLEGAL;
               d.asc = `ASC_SEQ_ERR;
            end else if (q.len != 24'd0) begin
               d.st = ST_XFER;
               if (dtc_class(q.dtc) == CLS_IMAGE) d.img_rd = 1'b1;
            end
         end
         ST_XFER: begin
            if (q.cnt == q.len) begin
               d.st = ST_FLUSH;
            end else if (q.cls == CLS_IMAGE) begin
               pk_ready = buf_ready;
               if (pk_valid) begin
                  push = buf_ready;
                  push_data = pk_byte;
                  if (buf_ready) d.cnt = q.cnt + 24'd1;
               end else if (img_end_i) begin
                  d.stat = `STAT_CHECK;
                  d.ili = 1'b1;
                  d.info_vld = 1'b1;
                  d.resid = q.len - q.cnt;
                  d.st = ST_FLUSH;
               end
            end else if (q.cnt == resp_len) begin
               d.stat = `STAT_CHECK;
               d.ili = 1'b1;
               d.info_vld = 1'b1;
               d.resid = q.len - q.cnt;
               d.st = ST_FLUSH;
            end else begin
               push = buf_ready;
               push_data = resp_byte;
               if (buf_ready) d.cnt = q.cnt + 24'd1;
            end
         end
         ST_FLUSH: begin
            // status only after the last byte has left the buffer
            if (buf_empty) d.st = ST_DONE;
         end
         ST_DONE: begin
            d.st = ST_IDLE;
         end
      endcase
      // only a fresh window (rising level) makes pixel counts readable again;
      // a window that merely stays configured must not undo an image read
      if (win_set_i && !q.win_q && q.st != ST_DEC && !(q.st == ST_XFER && q.cls == CLS_IMAGE)) begin
         d.img_rd = 1'b0;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.cls <= CLS_BAD;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign cdb_ready_o = (q.st == ST_IDLE);
   assign busy_o = (q.st != ST_IDLE);
   assign cmd_done_o = (q.st == ST_DONE);
   assign img_xfer_o = (q.st == ST_XFER) && (q.cls == CLS_IMAGE);
   assign win_id_o = q.wid;
   assign status_o = q.stat;
   assign sense_key_o = q.skey;
   assign asc_o = q.asc;
   assign ili_o = q.ili;
   assign info_valid_o = q.info_vld;
   assign info_o = {8'h00, q.resid};
endmodule : scanner_read_command_unit

// File: scanner_read_consts.svh
// shared constants for the scanner read command unit
// included by the package, the command unit, the monitor and the bench
`ifndef SCANNER_READ_CONSTS_SVH
`define SCANNER_READ_CONSTS_SVH
// command block layout
`define CDB_LEN 4'd10
`define CDB_OP 4'd0
`define CDB_DTC 4'd2
`define CDB_WID 4'd5
`define CDB_LEN_HI 4'd6
`define CDB_LEN_MID 4'd7
`define CDB_LEN_LO 4'd8
`define OP_READ10 8'h28
// data type codes
`define DTC_IMAGE 8'h00
`define DTC_HALFTONE 8'h02
`define DTC_GAMMA 8'h03
`define DTC_PIXEL 8'h80
`define DTC_PAPER 8'h81
// response lengths and layout
`define RESP_PIX_LEN 24'd16
`define RESP_PAPER_LEN 24'd8
`define PIX_X_END 24'd4
`define PIX_Y_END 24'd8
`define PAPER_SEP_BYTE 24'd2
`define PAPER_SIZE_BYTE 24'd3
`define PIX_DIV 40'd1200
`define SEP_SHEET_SEEN 8'h80
`define SEP_SHEET_NONE 8'h00
// paper size codes
`define SIZE_A3 4'h3
`define SIZE_A4 4'h4
`define SIZE_A5 4'h5
`define SIZE_B4 4'hb
`define SIZE_B5 4'hd
`define SIZE_NONE 4'h0
// status and sense
`define STAT_GOOD 8'h00
`define STAT_CHECK 8'h02
`define STAT_RESV 8'h18
`define SK_NONE 4'h0
`define SK_ILLEGAL 4'h5
`define ASC_NONE 8'h00
`define ASC_BAD_OPCODE 8'h20
`define ASC_BAD_FIELD 8'h24
`define ASC_SEQ_ERR 8'h2c
`endif

// File: scanner_read_pkg.sv
// types for the scanner read command unit
// assumes scanner_read_consts.svh is on the include path
`include "scanner_read_consts.svh"
package scanner_read_pkg;
   // controller states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_DEC   = 5'b00010,
      ST_XFER  = 5'b00100,
      ST_FLUSH = 5'b01000,
      ST_DONE  = 5'b10000
   } rd_st_t;

   // meaning of a data type code, shared by read and download paths
   typedef enum logic [2:0] {
      CLS_IMAGE, CLS_PIXEL, CLS_PAPER, CLS_DOWNLOAD, CLS_BAD
   } dtc_cls_t;

   typedef struct packed {
      rd_st_t st;
      logic [3:0] idx;
      logic [7:0] op;
      logic [7:0] dtc;
      logic [7:0] wid;
      logic [23:0] len;
      logic [23:0] cnt;
      dtc_cls_t cls;
      logic img_rd;
      logic win_q;
      logic [31:0] px_x;
      logic [31:0] px_y;
      logic [7:0] paper;
      logic [7:0] stat;
      logic [3:0] skey;
      logic [7:0] asc;
      logic ili;
      logic info_vld;
      logic [23:0] resid;
   } rd_state_t;

   // one decoder for both transfer directions
   function automatic dtc_cls_t dtc_class(input logic [7:0] code);
      dtc_cls_t c;
      c = CLS_BAD;
      if (code == `DTC_IMAGE) c = CLS_IMAGE;
      else if (code == `DTC_PIXEL) c = CLS_PIXEL;
      else if (code == `DTC_PAPER) c = CLS_PAPER;
      else if (code == `DTC_HALFTONE || code == `DTC_GAMMA) c = CLS_DOWNLOAD;
      return c;
   endfunction : dtc_class
endpackage : scanner_read_pkg

// File: rd_skid_buf2.sv
// two-entry buffer with valid/ready on both sides
// same clock on both sides; out_data_o is registered
`timescale 1ns/10ps
module rd_skid_buf2 #(
   parameter int WIDTH = 8
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i,
   output logic empty_o
);
   typedef struct packed {
      logic [WIDTH-1:0] e0;
      logic [WIDTH-1:0] e1;
      logic [1:0] fill;
   } buf_state_t;

   buf_state_t q;
   buf_state_t d;
   logic push;
   logic pop;
   logic [1:0] n;

   assign in_ready_o = (q.fill != 2'd2);
   assign out_valid_o = (q.fill != 2'd0);
   assign out_data_o = q.e0;
   assign empty_o = (q.fill == 2'd0);
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // shift on pop, then write at the first free slot
   always_comb begin
      d = q;
      n = q.fill;
      if (pop) begin
         d.e0 = q.e1;
         n = q.fill - 2'd1;
      end
      if (push) begin
         if (n == 2'd0) d.e0 = in_data_i;
         else d.e1 = in_data_i;
         n = n + 2'd1;
      end
      d.fill = n;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) q <= '0;
      else q <= d;
   end
endmodule : rd_skid_buf2

// File: rd_pix_pack.sv
// packs a one-bit pixel stream into bytes, leftmost pixel in bit 7
// pixels arrive left to right; last_i marks the final pixel of a raster line
`timescale 1ns/10ps
module rd_pix_pack (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic pix_valid_i,
   input wire logic pix_i,
   input wire logic last_i,
   output logic pix_ready_o,
   output logic byte_valid_o,
   output logic [7:0] byte_o,
   input wire logic byte_ready_i
);
   typedef struct packed {
      logic [7:0] sh;
      logic [2:0] n;
      logic ov;
      logic [7:0] ob;
   } pack_state_t;

   pack_state_t q;
   pack_state_t d;
   logic [7:0] nb;

   assign pix_ready_o = ~q.ov | byte_ready_i;
   assign byte_valid_o = q.ov;
   assign byte_o = q.ob;

   // fill from bit 7 down; a short line end pads the byte with zeros
   always_comb begin
      d = q;
      nb = q.sh | (8'(pix_i) << (3'd7 - q.n));
      if (q.ov && byte_ready_i) d.ov = 1'b0;
      if (pix_valid_i && pix_ready_o) begin
         if (q.n == 3'd7 || last_i) begin
            d.ob = nb;
            d.ov = 1'b1;
            d.sh = 8'h00;
            d.n = 3'd0;
         end else begin
            d.sh = nb;
            d.n = q.n + 3'd1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) q <= '0;
      else q <= d;
   end
endmodule : rd_pix_pack

// File: scanner_read_command_unit_monitor.sv
// checker for the scanner read command unit, bound to its top module
// assumes one clock domain and the shared constants header on the include path
`timescale 1ns/10ps
`include "scanner_read_consts.svh"
module scanner_read_command_unit_monitor (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic cdb_valid_i,
   input wire logic [7:0] cdb_byte_i,
   input wire logic cdb_ready_o,
   input wire logic resv_conflict_i,
   input wire logic img_xfer_o,
   input wire logic [7:0] win_id_o,
   input wire logic din_valid_o,
   input wire logic [7:0] din_data_o,
   input wire logic din_ready_i,
   input wire logic cmd_done_o,
   input wire logic busy_o,
   input wire logic [7:0] status_o,
   input wire logic [3:0] sense_key_o,
   input wire logic [7:0] asc_o,
   input wire logic ili_o,
   input wire logic info_valid_o,
   input wire logic [31:0] info_o
);
   logic [3:0] idx_q;
   logic [7:0] op_q, dtc_q, wid_q;
   logic [23:0] len_q, moved_q;
   logic take;
   assign take = cdb_valid_i && cdb_ready_o;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////
   // byte position in the command block and data-in bytes moved
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         idx_q <= 4'h0;
         moved_q <= 24'h0;
      end else begin
         if (cmd_done_o) idx_q <= 4'h0;
         else if (take) idx_q <= idx_q + 4'h1;
         if (take && idx_q == 4'h0) moved_q <= 24'h0;
         else if (din_valid_o && din_ready_i) moved_q <= moved_q + 24'h1;
      end
   end
   // command fields as they pass
   always_ff @(posedge mclk_i) begin
      if (take) begin
         case (idx_q)
            4'h0: op_q <= cdb_byte_i;
            4'h2: dtc_q <= cdb_byte_i;
            4'h5: wid_q <= cdb_byte_i;
            4'h6: len_q[23:16] <= cdb_byte_i;
            4'h7: len_q[15:8] <= cdb_byte_i;
            4'h8: len_q[7:0] <= cdb_byte_i;
            default: ;
         endcase
      end
   end
   ////////////////////////////////////////////////////////////
   AST_READY_IDLE: assert property (take && idx_q == 4'h9 |=> busy_o && !cdb_ready_o)
      else $error("tenth command byte did not start decode");
   AST_DONE_PULSE: assert property (cmd_done_o |=> !cmd_done_o)
      else $error("done too long");
   AST_ZERO_LATENCY: assert property (take && idx_q == 4'h9 && len_q == 24'h0 |-> ##[1:2] cmd_done_o)
      else $error("zero count not ended");
   AST_ZERO_NO_DATA: assert property (cmd_done_o && len_q == 24'h0 |-> moved_q == 24'h0 && !info_valid_o)
      else $error("zero count moved data");
   AST_NO_OVERRUN: assert property (din_valid_o && din_ready_i |-> moved_q < len_q)
      else $error("more bytes than count");
   AST_RESIDUE: assert property (cmd_done_o && info_valid_o |-> status_o == `STAT_CHECK && ili_o
      && info_o == {8'h00, len_q - moved_q}) else $error("bad residue");
   AST_CONFLICT: assert property (cmd_done_o && op_q == `OP_READ10 && resv_conflict_i
      |-> status_o == `STAT_RESV && moved_q == 24'h0) else $error("conflict not reported");
   AST_BAD_TYPE: assert property (cmd_done_o && op_q == `OP_READ10 && !resv_conflict_i
      && !(dtc_q inside {8'h00, 8'h80, 8'h81}) |-> status_o == `STAT_CHECK && sense_key_o == `SK_ILLEGAL
      && asc_o == `ASC_BAD_FIELD && moved_q == 24'h0) else $error("bad type accepted");
   AST_HOLD_WORD: assert property (din_valid_o && !din_ready_i |=> din_valid_o && $stable(din_data_o))
      else $error("stalled byte changed");
   AST_IMAGE_WINDOW: assert property (img_xfer_o |-> dtc_q == 8'h00 && win_id_o == wid_q)
      else $error("image phase mismatch");
   COV_SHORT: cover property (cmd_done_o && info_valid_o);
   COV_CONFLICT: cover property (cmd_done_o && status_o == `STAT_RESV);
   COV_STALL: cover property (din_valid_o && !din_ready_i);
endmodule : scanner_read_command_unit_monitor
bind scanner_read_command_unit scanner_read_command_unit_monitor i_scanner_read_command_unit_monitor (.*);

// File: scsi_initiator_model.sv
// far-side initiator model: takes data-in bytes, with optional stalls
// assumes a byte moves when the target's valid and this ready are both high
`timescale 1ns/10ps
module scsi_initiator_model (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic stall_i,
   output logic din_ready_o
);
   logic [1:0] phase_q;
   // ready every cycle, or one cycle in four while stalling
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_q <= 2'h0;
         din_ready_o <= 1'b0;
      end else begin
         phase_q <= phase_q + 2'h1;
         din_ready_o <= !stall_i || phase_q == 2'h3;
      end
   end
endmodule : scsi_initiator_model

// File: tb_scanner_read_command_unit.sv
// self-checking bench for the scanner read command unit
// assumes the shared constants header and the initiator model are compiled alongside
`timescale 1ns/10ps
`include "scanner_read_consts.svh"
module tb_scanner_read_command_unit;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, cdb_valid_i = 1'b0, resv_conflict_i = 1'b0, win_set_i = 1'b0;
   logic sep_sheet_i = 1'b0, pos_done_i = 1'b0, paper_loaded_i = 1'b0, size_known_i = 1'b0, landscape_i = 1'b0;
   logic pix_valid_i = 1'b0, pix_i = 1'b0, pix_last_i = 1'b0, img_end_i = 1'b0, stall = 1'b0;
   logic [7:0] cdb_byte_i = 8'h00;
   logic [15:0] x_res_i = 16'h0000, y_res_i = 16'h0000, rnd = 16'h0032;
   logic [23:0] width_i = 24'h0, length_i = 24'h0;
   logic [3:0] size_code_i = 4'h0, sense_key_o;
   logic cdb_ready_o, pix_ready_o, img_xfer_o, din_valid_o, din_ready_i, cmd_done_o, busy_o, ili_o, info_valid_o;
   logic [7:0] win_id_o, din_data_o, status_o, asc_o;
   logic [31:0] info_o;
   logic [7:0] exp_b[$];
   logic [53:0] exp_s[$];
   int fail_count = 0, comparisons = 0, cycles = 0;
   scanner_read_command_unit i_scanner_read_command_unit (.*);
   scsi_initiator_model i_scsi_initiator_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .stall_i(stall),
      .din_ready_o(din_ready_i));
   always #25 mclk_i = ~mclk_i;
   ////////////////////////////////////////////////////////////
   function logic [15:0] nxt();
      rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
      return rnd;
   endfunction : nxt
   // ending status note: status, sense key, code, ili, valid, information
   function automatic logic [53:0] st(input logic [7:0] s, input logic [3:0] k, input logic [7:0] a,
         input logic [23:0] r);
      return {s, k, a, r != 24'h0, r != 24'h0, 8'h00, r};
   endfunction : st
   task automatic chk(input string what, input logic [53:0] e, input logic [53:0] g);
      comparisons++;
      if (e !== g) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic wrap_up();
      if (fail_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : wrap_up
   // expected reply bytes, taken from the top of rep
   task automatic note(input logic [127:0] rep, input int nb);
      for (int i = 0; i < nb; i++) exp_b.push_back(rep[127 - 8 * i -: 8]);
   endtask : note
   // one command block, each byte held until taken
   task automatic cmd(input logic [7:0] op, input logic [7:0] dtc, input logic [7:0] wid, input logic [23:0] len,
         input logic [53:0] e);
      logic [7:0] b[10];
      b = '{op, 8'h00, dtc, 8'h00, 8'h00, wid, len[23:16], len[15:8], len[7:0], 8'h00};
      exp_s.push_back(e);
      for (int i = 0; i < 10; i++) begin
         cdb_valid_i <= 1'b1;
         cdb_byte_i <= b[i];
         do @(posedge mclk_i); while (!cdb_ready_o);
      end
      cdb_valid_i <= 1'b0;
   endtask : cmd
   task automatic fin();
      do @(posedge mclk_i); while (!cmd_done_o);
      @(posedge mclk_i);
   endtask : fin
   ////////////////////////////////////////////////////////////
   // watcher: compares each delivered byte and each ending status with the oldest note
   always @(posedge mclk_i) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up();
      end
      if (rst_n_i && din_valid_o && din_ready_i) chk("din_data_o",
         exp_b.size() ? {46'h0, exp_b.pop_front()} : {54{1'bx}}, {46'h0, din_data_o});
      if (rst_n_i && cmd_done_o) chk("ending status",
         exp_s.size() ? exp_s.pop_front() : {54{1'bx}}, {status_o, sense_key_o, asc_o, ili_o, info_valid_o, info_o});
   end
   // main sequence
   initial begin
      static logic [7:0] codes[5] = '{8'h02, 8'h03, 8'h04, 8'h7f, 8'h82};
      static logic [3:0] sizes[6] = '{4'h3, 4'h4, 4'h5, 4'hb, 4'hd, 4'h4};
      logic [15:0] r, xr, yr;
      logic [23:0] wd, ln;
      logic [39:0] xp, yp;
      logic [9:0] p;
      logic [7:0] sz, b0;
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
      cmd(8'h2a, 8'h00, 8'h00, 24'h4, st(`STAT_CHECK, `SK_ILLEGAL, `ASC_BAD_OPCODE, 24'h0));
      fin();
      resv_conflict_i <= 1'b1;
      cmd(`OP_READ10, `DTC_IMAGE, 8'h00, 24'h5, st(`STAT_RESV, `SK_NONE, `ASC_NONE, 24'h0));
      fin();
      resv_conflict_i <= 1'b0;
      foreach (codes[i]) begin
         cmd(`OP_READ10, codes[i], 8'h00, 24'h8, st(`STAT_CHECK, `SK_ILLEGAL, `ASC_BAD_FIELD, 24'h0));
         fin();
      end
      cmd(`OP_READ10, `DTC_IMAGE, 8'h00, 24'h0, st(`STAT_GOOD, `SK_NONE, `ASC_NONE, 24'h0));
      fin();
      cmd(`OP_READ10, `DTC_PIXEL, 8'h00, 24'h10, st(`STAT_CHECK, `SK_ILLEGAL, `ASC_SEQ_ERR, 24'h0));
      fin();
      // pixel counts with the receiver stalling, exact and long count
      win_set_i <= 1'b1;
      stall <= 1'b1;
      for (int n = 0; n < 2; n++) begin
         xr = nxt();
         yr = nxt();
         wd = {8'h00, nxt()};
         ln = {8'h00, nxt()};
         x_res_i <= xr;
         y_res_i <= yr;
         width_i <= wd;
         length_i <= ln;
         xp = ({24'h0, xr} * {16'h0, wd}) / `PIX_DIV;
         yp = ({24'h0, yr} * {16'h0, ln}) / `PIX_DIV;
         note({xp[31:0], yp[31:0], 64'h0}, 16);
         cmd(`OP_READ10, `DTC_PIXEL, 8'h00, 24'(16 + 4 * n), st(n ? `STAT_CHECK : `STAT_GOOD, `SK_NONE, `ASC_NONE,
            24'(4 * n)));
         fin();
      end
      // paper information over every size code, one unknown size
      for (int n = 0; n < 6; n++) begin
         r = nxt();
         sep_sheet_i <= r[0];
         pos_done_i <= r[1];
         paper_loaded_i <= r[2];
         landscape_i <= r[3] && n < 5;
         size_known_i <= n < 5;
         size_code_i <= sizes[n];
         sz = {1'b0, r[2] & r[1], n == 5, r[3] && n < 5, n == 5 ? 4'h0 : sizes[n]};
         ln = (n == 0) ? 24'ha : (n == 1) ? 24'h3 : 24'h8;
         note({16'h0, r[0] ? 8'h80 : 8'h00, sz, 96'h0}, ln > 24'h8 ? 8 : int'(ln));
         cmd(`OP_READ10, `DTC_PAPER, 8'h00, ln, st(ln > 24'h8 ? `STAT_CHECK : `STAT_GOOD, `SK_NONE, `ASC_NONE,
            ln > 24'h8 ? ln - 24'h8 : 24'h0));
         fin();
      end
      // image read of one ten-pixel line, source ends one byte short; window stays set
      r = nxt();
      p = r[9:0];
      b0 = {<<{p[7:0]}};
      note({b0, p[8], p[9], 6'h00, 112'h0}, 2);
      cmd(`OP_READ10, `DTC_IMAGE, r[15:8], 24'h3, st(`STAT_CHECK, `SK_NONE, `ASC_NONE, 24'h1));
      do @(posedge mclk_i); while (!img_xfer_o);
      chk("win_id_o", {46'h0, r[15:8]}, {46'h0, win_id_o});
      for (int i = 0; i < 10; i++) begin
         pix_valid_i <= 1'b1;
         pix_i <= p[i];
         pix_last_i <= (i == 9);
         do @(posedge mclk_i); while (!(pix_ready_o && img_xfer_o));
      end
      pix_valid_i <= 1'b0;
      pix_last_i <= 1'b0;
      img_end_i <= 1'b1;
      fin();
      img_end_i <= 1'b0;
      // pixel counts refused once image data has been read
      cmd(`OP_READ10, `DTC_PIXEL, 8'h00, 24'h10, st(`STAT_CHECK, `SK_ILLEGAL, `ASC_SEQ_ERR, 24'h0));
      fin();
      repeat (4) @(posedge mclk_i);
      chk("pending notes", 54'h0, 54'(exp_b.size() + exp_s.size()));
      wrap_up();
   end
endmodule : tb_scanner_read_command_unit
